// [include/link_seq_pkg.sv]
// shared constants and types for the serial link startup sequencer
package link_seq_pkg;
  // control symbol: comma K28.5 and ILA markers as 8b codes with k flag
  localparam logic [7:0] COMMA_CHAR = 8'hBC;
  localparam logic [7:0] ILA_START_CHAR = 8'h1C;
  localparam logic [7:0] ILA_END_CHAR = 8'h7C;
  localparam logic [7:0] ILA_CFG_CHAR = 8'h9C;
  // multiframes in the initial lane alignment sequence
  localparam int ILA_MULTIFRAMES = 4;
  // octets per frame
  localparam int OCTETS_PER_FRAME = 2;
  // reset values of the held configuration
  localparam logic [4:0] FRAMES_M1_RESET = 5'h1F;
  localparam logic [5:0] DECIM_RESET = 6'h04;
  localparam logic [1:0] RATE_RESET = 2'h0;
  // link state
  typedef enum logic [2:0] {
    ST_OFF, ST_WAIT_SYNC, ST_CGS, ST_ILA, ST_DATA
  } link_state_t;
endpackage

// [include/lane_if.sv]
// carrier between the sequencer and its lane symbol formatter
`timescale 1ns/100ps
interface lane_if;
  logic [1:0] sel; // 0 idle, 1 comma, 2 ila, 3 data
  logic [7:0] ila_char; // ila octet chosen by the sequencer
  logic ila_k; // ila octet is a control char
  logic [7:0] data; // sample octet
  modport ctrl (output sel, output ila_char, output ila_k, output data);
  modport fmt (input sel, input ila_char, input ila_k, input data);
endinterface

// [rtl/lane_formatter.sv]
// per-lane symbol formatter with registered outputs
`timescale 1ns/100ps
module lane_formatter #(
  parameter int LANES = 5
) (
  input wire logic sys_clk,
  input wire logic resetn,
  lane_if.fmt lane,
  output logic [LANES*8-1:0] tx_octet,
  output logic [LANES-1:0] tx_is_k
);
  // every lane carries the same control stream; data is shared too
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      // registered output, idle drives zero
      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          tx_octet[g*8 +: 8] <= 8'h00;
          tx_is_k[g] <= 1'b0;
        end
        else
        begin
          case (lane.sel)
            2'h1:
            begin
              tx_octet[g*8 +: 8] <= link_seq_pkg::COMMA_CHAR;
              tx_is_k[g] <= 1'b1;
            end
            2'h2:
            begin
              tx_octet[g*8 +: 8] <= lane.ila_char;
              tx_is_k[g] <= lane.ila_k;
            end
            2'h3:
            begin
              tx_octet[g*8 +: 8] <= lane.data;
              tx_is_k[g] <= 1'b0;
            end
            default:
            begin
              tx_octet[g*8 +: 8] <= 8'h00;
              tx_is_k[g] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate
endmodule // lane_formatter

// [rtl/serial_link_startup_sequencer.sv]
// startup sequencer for a subclass 1 serial transmit link
// Operation
// - enable low stops link, allows config
// - enable high after calibration starts link
// - sync asserted starts code group synchronization
// - sync released starts lane alignment sequence
// - data follows last alignment frame, no gap
`timescale 1ns/100ps
module serial_link_startup_sequencer #(
  parameter int LANES = 5
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic link_enable_bit,
  input wire logic [5:0] decimation_factor,
  input wire logic scrambler_enable,
  input wire logic [4:0] frames_per_multiframe_minus_one,
  input wire logic [1:0] link_rate_select,
  input wire logic software_calibration_trigger,
  input wire logic sysref,
  input wire logic sync_n,
  input wire logic [7:0] sample_octet,
  output logic [LANES*8-1:0] tx_octet,
  output logic [LANES-1:0] tx_is_k,
  output logic [5:0] active_decimation,
  output logic active_scrambler,
  output logic [4:0] active_frames_m1,
  output logic [1:0] active_rate,
  output logic cal_start,
  output logic lmfc_aligned,
  output logic link_running,
  output logic [2:0] link_state
);
  link_seq_pkg::link_state_t state_q; // sequence position
  logic [4:0] frame_q; // frame count inside multiframe
  logic [0:0] octet_q; // octet count inside frame
  logic [1:0] mf_q; // ila multiframe count
  logic sysref_q; // previous sysref for edge detect
  logic cal_trig_q; // previous trigger for edge detect
  logic lmfc_aligned_q; // sysref seen since enable
  logic frame_end; // last octet of a frame
  logic mf_end; // last octet of a multiframe
  logic sysref_rise; // rising edge of sysref
  lane_if lane(); // to formatter

  // last octet index inside a frame
  localparam int OCTETS_PER_FRAME_M1 = link_seq_pkg::OCTETS_PER_FRAME - 1;

  assign frame_end = (octet_q == 1'(OCTETS_PER_FRAME_M1));
  assign mf_end = frame_end && (frame_q == active_frames_m1);
  assign sysref_rise = sysref && !sysref_q;

  // config is latched only while the link is off; it holds while running
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      active_decimation <= link_seq_pkg::DECIM_RESET;
      active_scrambler <= 1'b0;
      active_frames_m1 <= link_seq_pkg::FRAMES_M1_RESET;
      active_rate <= link_seq_pkg::RATE_RESET;
    end
    else if (!link_enable_bit)
    begin
      active_decimation <= decimation_factor;
      active_scrambler <= scrambler_enable;
      active_frames_m1 <= frames_per_multiframe_minus_one;
      active_rate <= link_rate_select;
    end
  end

  // edge detectors for the calibration trigger and sysref
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sysref_q <= 1'b0;
      cal_trig_q <= 1'b0;
    end
    else
    begin
      sysref_q <= sysref;
      cal_trig_q <= software_calibration_trigger;
    end
  end

  // one-cycle calibration start pulse; only when link is off
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      cal_start <= 1'b0;
    else
      cal_start <= software_calibration_trigger && !cal_trig_q
        && !link_enable_bit;
  end

  // local multiframe counter; sysref edge resets the phase
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      octet_q <= 1'b0;
      frame_q <= 5'h00;
      lmfc_aligned_q <= 1'b0;
    end
    else if (!link_enable_bit)
    begin
      octet_q <= 1'b0;
      frame_q <= 5'h00;
      lmfc_aligned_q <= 1'b0;
    end
    else if (sysref_rise)
    begin
      // the edge marks octet zero of a new multiframe
      octet_q <= 1'b0;
      frame_q <= 5'h00;
      lmfc_aligned_q <= 1'b1;
    end
    else
    begin
      // free-running without sysref, so alignment is optional
      octet_q <= frame_end ? 1'b0 : octet_q + 1'b1;
      if (mf_end)
        frame_q <= 5'h00;
      else if (frame_end)
        frame_q <= frame_q + 5'h01;
    end
  end

  // link state machine
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= link_seq_pkg::ST_OFF;
      mf_q <= 2'h0;
    end
    else if (!link_enable_bit)
      state_q <= link_seq_pkg::ST_OFF;
    else
    begin
      case (state_q)
        link_seq_pkg::ST_OFF:
          state_q <= link_seq_pkg::ST_WAIT_SYNC;
        link_seq_pkg::ST_WAIT_SYNC:
          if (!sync_n)
            state_q <= link_seq_pkg::ST_CGS;
        link_seq_pkg::ST_CGS:
          // ila starts on a multiframe boundary after sync release
          if (sync_n && mf_end)
          begin
            state_q <= link_seq_pkg::ST_ILA;
            mf_q <= 2'h0;
          end
        link_seq_pkg::ST_ILA:
          if (!sync_n)
            state_q <= link_seq_pkg::ST_CGS;
          else if (mf_end)
          begin
            if (mf_q == 2'(link_seq_pkg::ILA_MULTIFRAMES - 1))
              state_q <= link_seq_pkg::ST_DATA;
            mf_q <= mf_q + 2'h1;
          end
        link_seq_pkg::ST_DATA:
          // a resync request drops back to commas
          if (!sync_n)
            state_q <= link_seq_pkg::ST_CGS;
        default:
          state_q <= link_seq_pkg::ST_OFF;
      endcase
    end
  end

  // lane stream selection; comma while sync is low in cgs
  always_comb
  begin
    lane.data = sample_octet;
    lane.ila_k = 1'b0;
    lane.ila_char = 8'h00;
    case (state_q)
      link_seq_pkg::ST_CGS:
        lane.sel = 2'h1;
      link_seq_pkg::ST_ILA:
      begin
        lane.sel = 2'h2;
        // framed markers: start, config frame, end of each multiframe
        if (frame_q == 5'h00 && octet_q == 1'b0)
        begin
          lane.ila_char = link_seq_pkg::ILA_START_CHAR;
          lane.ila_k = 1'b1;
        end
        else if (mf_q == 2'h1 && frame_q == 5'h01 && octet_q == 1'b0)
        begin
          lane.ila_char = link_seq_pkg::ILA_CFG_CHAR;
          lane.ila_k = 1'b1;
        end
        else if (mf_end)
        begin
          lane.ila_char = link_seq_pkg::ILA_END_CHAR;
          lane.ila_k = 1'b1;
        end
        else
          lane.ila_char = {3'h0, frame_q};
      end
      link_seq_pkg::ST_DATA:
        lane.sel = 2'h3;
      default:
        lane.sel = 2'h0;
    endcase
  end

  lane_formatter #(.LANES(LANES)) i_lane_formatter (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .lane(lane),
    .tx_octet(tx_octet),
    .tx_is_k(tx_is_k)
  );

  assign lmfc_aligned = lmfc_aligned_q;
  assign link_running = (state_q == link_seq_pkg::ST_DATA);
  assign link_state = state_q;
endmodule // serial_link_startup_sequencer

// [dv/link_seq_chk.sv]
// port checks for the link startup sequencer
`timescale 1ns/100ps
module link_seq_chk #(
  parameter int LANES = 5
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic link_enable_bit,
  input wire logic [4:0] frames_per_multiframe_minus_one,
  input wire logic sync_n,
  input wire logic [LANES*8-1:0] tx_octet,
  input wire logic [LANES-1:0] tx_is_k,
  input wire logic [4:0] active_frames_m1,
  input wire logic cal_start,
  input wire logic link_running,
  input wire logic [2:0] link_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // alignment state handing straight over to data
  sequence ila_to_data_s;
    $past(link_state) == link_seq_pkg::ST_ILA
      && link_state == link_seq_pkg::ST_DATA;
  endsequence
  // sync release moving code sync into alignment
  sequence cgs_to_ila_s;
    $past(link_state) == link_seq_pkg::ST_CGS
      && link_state == link_seq_pkg::ST_ILA;
  endsequence
  // first alignment octet is the multiframe start marker
  sequence ila_start_s;
    tx_octet[7:0] == link_seq_pkg::ILA_START_CHAR && tx_is_k[0];
  endsequence
  cal_refused_a: assert property (
    $past(link_enable_bit) |-> !cal_start)
    else $error("calibration pulse while link enabled");
  cfg_frozen_a: assert property (
    $past(link_enable_bit) |-> $stable(active_frames_m1))
    else $error("config moved while link enabled");
  cfg_follow_a: assert property (
    $past(resetn) && !$past(link_enable_bit)
    |-> active_frames_m1 == $past(frames_per_multiframe_minus_one))
    else $error("config not taken while link disabled");
  link_off_a: assert property (!link_enable_bit |=> link_state == 3'h0)
    else $error("link not off after disable");
  wait_sync_a: assert property (link_enable_bit && sync_n
    && link_state == 3'h0 |=> link_state == 3'h1)
    else $error("enable did not start the link");
  cgs_enter_a: assert property (link_enable_bit && !sync_n
    && link_state == 3'h1 |=> link_state == 3'h2)
    else $error("sync request did not start code sync");
  comma_fill_a: assert property ($past(link_state) == 3'h2
    |-> tx_octet == {LANES{link_seq_pkg::COMMA_CHAR}} && &tx_is_k)
    else $error("lanes not sending commas");
  // the end marker stands last, then plain data with no gap
  ila_gapless_a: assert property (ila_to_data_s
    |-> (tx_octet[7:0] == link_seq_pkg::ILA_END_CHAR && tx_is_k[0])
    ##1 (tx_is_k == '0))
    else $error("data did not follow alignment end");
  // steady running data never carries a control octet
  running_flag_a: assert property (
    link_running && $past(link_running) |-> tx_is_k == '0)
    else $error("control octet inside running data");
  // alignment only after sync release, opening with the start marker
  ila_start_a: assert property (cgs_to_ila_s
    |-> $past(sync_n) ##1 ila_start_s)
    else $error("alignment did not open with start marker");
endmodule // link_seq_chk
bind serial_link_startup_sequencer
  link_seq_chk #(.LANES(LANES)) i_link_seq_chk (
  .sys_clk(sys_clk), .resetn(resetn), .link_enable_bit(link_enable_bit),
  .frames_per_multiframe_minus_one(frames_per_multiframe_minus_one),
  .sync_n(sync_n), .tx_octet(tx_octet), .tx_is_k(tx_is_k),
  .active_frames_m1(active_frames_m1), .cal_start(cal_start),
  .link_running(link_running), .link_state(link_state));

// [dv/link_rx_model.sv]
// receiver model: asks for sync, releases it after four commas
`timescale 1ns/100ps
module link_rx_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic request,
  input wire logic [7:0] lane0_octet,
  input wire logic lane0_k,
  output logic sync_n
);
  logic [2:0] comma_count_q; // commas seen since the request
  // non-blocking on the rising edge: the bench moves request on the
  // falling edge, so sampling it here never races the driver
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      comma_count_q <= 3'h0;
      sync_n <= 1'b1;
    end
    else if (!request)
    begin
      // idle receiver leaves sync released
      comma_count_q <= 3'h0;
      sync_n <= 1'b1;
    end
    else if (comma_count_q == 3'h4)
      sync_n <= 1'b1;
    else
    begin
      sync_n <= 1'b0;
      if (lane0_k && lane0_octet == link_seq_pkg::COMMA_CHAR)
        comma_count_q <= comma_count_q + 3'h1;
    end
  end
endmodule // link_rx_model

// [dv/serial_link_startup_sequencer_bench.sv]
// bench walking the link through bring-up twice
`timescale 1ns/100ps
module serial_link_startup_sequencer_bench;
  localparam int LANES = 2;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic link_enable_bit, scrambler_enable, software_calibration_trigger;
  logic sysref, sync_n, request, cal_start, lmfc_aligned, link_running;
  logic active_scrambler;
  logic [5:0] decimation_factor, active_decimation;
  logic [4:0] frames_per_multiframe_minus_one, active_frames_m1;
  logic [1:0] link_rate_select, active_rate;
  logic [7:0] sample_octet;
  logic [2:0] link_state;
  logic [LANES*8-1:0] tx_octet;
  logic [LANES-1:0] tx_is_k;
  int fail_count = 0;
  int check_count = 0;
  always #50 sys_clk = ~sys_clk;
  serial_link_startup_sequencer #(.LANES(LANES))
    i_serial_link_startup_sequencer (
    .sys_clk(sys_clk), .resetn(resetn), .link_enable_bit(link_enable_bit),
    .decimation_factor(decimation_factor), .scrambler_enable(scrambler_enable),
    .frames_per_multiframe_minus_one(frames_per_multiframe_minus_one),
    .link_rate_select(link_rate_select), .sysref(sysref), .sync_n(sync_n),
    .software_calibration_trigger(software_calibration_trigger),
    .sample_octet(sample_octet), .tx_octet(tx_octet), .tx_is_k(tx_is_k),
    .active_decimation(active_decimation), .active_scrambler(active_scrambler),
    .active_frames_m1(active_frames_m1), .active_rate(active_rate),
    .cal_start(cal_start),
    .lmfc_aligned(lmfc_aligned), .link_running(link_running),
    .link_state(link_state));
  link_rx_model i_link_rx_model (.sys_clk(sys_clk), .resetn(resetn),
    .request(request), .lane0_octet(tx_octet[7:0]), .lane0_k(tx_is_k[0]),
    .sync_n(sync_n));
  task complete_run;
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // bounded wait; a state never reached ends the run
  task wait_state(input logic [2:0] s);
    int i;
    for (i = 0; i < 400 && link_state !== s; i++)
      @(negedge sys_clk);
    check(link_state, s);
    if (link_state !== s)
      complete_run();
  endtask
  initial
  begin
    {link_enable_bit, scrambler_enable, sysref, request} = 4'h0;
    software_calibration_trigger = 1'b0;
    {decimation_factor, link_rate_select} = {6'h08, 2'h2};
    frames_per_multiframe_minus_one = 5'h03;
    sample_octet = 8'h5A;
    step(2);
    check(active_frames_m1, link_seq_pkg::FRAMES_M1_RESET);
    check(active_decimation, link_seq_pkg::DECIM_RESET);
    check({active_rate, active_scrambler, link_state}, 6'h00);
    resetn = 1'b1;
    for (int pass = 0; pass < 2; pass++)
    begin
      frames_per_multiframe_minus_one = 5'h03 << pass;
      scrambler_enable = 1'b1;
      step(2);
      check(active_frames_m1, 5'h03 << pass);
      check({active_decimation, active_rate}, 8'h22);
      check(active_scrambler, 1'b1);
      software_calibration_trigger = 1'b1;
      step(1);
      check(cal_start, 1'b1);
      software_calibration_trigger = 1'b0;
      link_enable_bit = 1'b1;
      step(1);
      check(link_state, link_seq_pkg::ST_WAIT_SYNC);
      // changes while running must be ignored
      frames_per_multiframe_minus_one = 5'h1E;
      software_calibration_trigger = 1'b1;
      step(1);
      check(cal_start, 1'b0);
      check(active_frames_m1, 5'h03 << pass);
      {software_calibration_trigger, sysref} = {1'b0, pass == 0};
      step(2);
      check(lmfc_aligned, pass == 0);
      {sysref, request} = 2'h1;
      wait_state(link_seq_pkg::ST_CGS);
      step(1);
      check({tx_is_k, tx_octet}, {2'h3, {LANES{8'hBC}}});
      wait_state(link_seq_pkg::ST_ILA);
      wait_state(link_seq_pkg::ST_DATA);
      step(1);
      check({link_running, tx_is_k, tx_octet}, {3'h4, 16'h5A5A});
      // receiver asks for sync again: back to commas, then realign
      request = 1'b0;
      step(1);
      request = 1'b1;
      wait_state(link_seq_pkg::ST_CGS);
      wait_state(link_seq_pkg::ST_DATA);
      {link_enable_bit, request} = 2'h0;
      step(1);
      check(link_state, link_seq_pkg::ST_OFF);
    end
    complete_run();
  end
endmodule // serial_link_startup_sequencer_bench
